// File: hw/dbp_port.sv
// Debug serial port: halts the core on request, takes serial commands,
// returns register data and drives chip status outside debug mode.
// Assumes pins are asynchronous to mclk and the shift clock is slow.
`timescale 1ns/1ps
// How it works
// - Serial input bits are taken only while in debug mode.
// - Input bits are sampled on falling edges of the shift clock.
// - Commands and data are shifted in most significant bit first.
// - Outside debug mode the data-in pin drives chip status bit 0.
// - Outside debug mode the clock pin drives chip status bit 1.
// - Pins pass through a tri-stated period when changing direction.
// - Output data go out MSB first, updated on rising shift clock edges.
// - Output data come from the register named by the last command.
// - Entering debug mode gives a low acknowledge pulse on the output.
// - After a read command, a low pulse marks data ready, then shifting.
// - Write command: pulse when ready for data, pulse again after writing.
// - Request: finish instruction, save pipeline, enter debug, await commands.
// - Request assert and release in debug mode resets the command logic.
// - A debug request wakes the core from stop or wait.
// - Request held at reset release starts the core in debug mode.
module dbp_port
  import dbp_pkg::*;
#(
  parameter int CMD_W = DBP_CMD_W,
  parameter int DATA_W = DBP_DATA_W,
  parameter int ADDR_W = DBP_ADDR_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic debug_data_in,
  output logic chip_status_bit0,
  output logic chip_status_bit0_oe_n,
  input wire logic debug_shift_clock,
  output logic chip_status_bit1,
  output logic chip_status_bit1_oe_n,
  output logic debug_serial_out,
  input wire logic debug_request_n,
  input wire logic [1:0] core_status,
  input wire logic core_instr_done,
  output logic core_halt_req,
  output logic core_save_pipe,
  output logic core_wake,
  output logic debug_mode
);

  logic din_s;
  logic sclk_s;
  logic req_n_s;
  logic sclk_p_r;
  logic req_n_p_r;
  logic sclk_fall;
  logic sclk_rise;
  logic req_assert;

  dbp_state_t st_r;
  dbp_state_t st_nxt;
  dbp_state_t ackn_r;
  dbp_state_t ackn_nxt;
  logic [DBP_CNT_W-1:0] cnt_r;
  logic [DBP_CNT_W-1:0] cnt_nxt;
  logic [CMD_W-1:0] cmd_r;
  logic [CMD_W-1:0] cmd_nxt;
  logic [CMD_W-1:0] cmd_in;
  logic [DATA_W-1:0] sr_r;
  logic [DATA_W-1:0] sr_nxt;
  logic sout_r;
  logic sout_nxt;
  logic wake_nxt;
  logic save_nxt;
  logic halt_nxt;
  logic dbg_nxt;
  logic drive_r;
  logic drive_nxt;
  logic [1:0] stat_r;
  logic reg_we;
  logic reg_re;
  logic [DATA_W-1:0] reg_rdata;
  logic in_cmd_phase;
  logic sr_msb;

  // Pin inputs cross into mclk before any logic looks at them
  dbp_sync #(
    .W(3),
    .INIT({1'h0, 1'h0, DBP_REQ_IDLE})
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d({debug_data_in, debug_shift_clock, debug_request_n}),
    .q({din_s, sclk_s, req_n_s})
  );

  dbp_regs #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W),
    .DEPTH(DBP_REG_N)
  ) u_regs (
    .mclk(mclk),
    .rstn(rstn),
    .we(reg_we),
    .re(reg_re),
    .addr(cmd_r[ADDR_W-1:0]),
    .wdata(sr_r),
    .rdata(reg_rdata)
  );

  assign sclk_fall = sclk_p_r & ~sclk_s;
  assign sclk_rise = ~sclk_p_r & sclk_s;
  assign req_assert = req_n_p_r & ~req_n_s;
  assign cmd_in = {cmd_r[CMD_W-2:0], din_s};
  assign sr_msb = sr_r[DATA_W-1];
  assign in_cmd_phase = (st_r == ST_WAITREL) || (st_r == ST_CMD) ||
    (st_r == ST_RD_FETCH) || (st_r == ST_RD_LOAD) ||
    (st_r == ST_RD_SHIFT) || (st_r == ST_WR_SHIFT) ||
    (st_r == ST_WR_COMMIT);

  always_comb begin
    st_nxt = st_r;
    ackn_nxt = ackn_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    sr_nxt = sr_r;
    sout_nxt = sout_r;
    wake_nxt = 1'h0;
    save_nxt = 1'h0;
    reg_we = 1'h0;
    reg_re = 1'h0;
    case (st_r)
      ST_BOOT: begin
        cnt_nxt = cnt_r + 1'h1;
        if (cnt_r == DBP_CNT_W'(DBP_BOOT_CYC - 1)) begin
          cnt_nxt = '0;
          st_nxt = req_n_s ? ST_RUN : ST_RELEASE;
        end
      end
      ST_RUN: begin
        if (req_assert) begin
          wake_nxt = 1'h1;
          st_nxt = ST_HALTING;
        end
      end
      ST_HALTING: begin
        if (core_instr_done) begin
          save_nxt = 1'h1;
          cnt_nxt = '0;
          st_nxt = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        cnt_nxt = cnt_r + 1'h1;
        if (cnt_r == DBP_CNT_W'(DBP_TRI_CYC - 1)) begin
          cnt_nxt = '0;
          ackn_nxt = ST_WAITREL;
          st_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        // Line goes low a cycle after entry, so the state lasts one more
        sout_nxt = ~DBP_SOUT_IDLE;
        cnt_nxt = cnt_r + 1'h1;
        if (cnt_r == DBP_CNT_W'(DBP_ACK_CYC)) begin
          cnt_nxt = '0;
          sout_nxt = DBP_SOUT_IDLE;
          st_nxt = ackn_r;
        end
      end
      ST_WAITREL: begin
        // Commands start only after the request is let go
        if (req_n_s) begin
          cnt_nxt = '0;
          cmd_nxt = '0;
          st_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        if (sclk_fall) begin
          cmd_nxt = cmd_in;
          cnt_nxt = cnt_r + 1'h1;
          if (cnt_r == DBP_CNT_W'(CMD_W - 1)) begin
            cnt_nxt = '0;
            if (cmd_in[DBP_CMD_GO_BIT]) begin
              st_nxt = ST_EXIT;
            end else if (cmd_in[DBP_CMD_RD_BIT]) begin
              st_nxt = ST_RD_FETCH;
            end else begin
              ackn_nxt = ST_WR_SHIFT;
              st_nxt = ST_ACK;
            end
          end
        end
      end
      ST_RD_FETCH: begin
        reg_re = 1'h1;
        st_nxt = ST_RD_LOAD;
      end
      ST_RD_LOAD: begin
        sr_nxt = reg_rdata;
        ackn_nxt = ST_RD_SHIFT;
        st_nxt = ST_ACK;
      end
      ST_RD_SHIFT: begin
        if (sclk_rise) begin
          sout_nxt = sr_msb;
          sr_nxt = {sr_r[DATA_W-2:0], 1'h0};
        end
        if (sclk_fall) begin
          cnt_nxt = cnt_r + 1'h1;
          if (cnt_r == DBP_CNT_W'(DATA_W - 1)) begin
            cnt_nxt = '0;
            sout_nxt = DBP_SOUT_IDLE;
            cmd_nxt = '0;
            st_nxt = ST_CMD;
          end
        end
      end
      ST_WR_SHIFT: begin
        if (sclk_fall) begin
          sr_nxt = {sr_r[DATA_W-2:0], din_s};
          cnt_nxt = cnt_r + 1'h1;
          if (cnt_r == DBP_CNT_W'(DATA_W - 1)) begin
            cnt_nxt = '0;
            st_nxt = ST_WR_COMMIT;
          end
        end
      end
      ST_WR_COMMIT: begin
        reg_we = 1'h1;
        cmd_nxt = '0;
        ackn_nxt = ST_CMD;
        st_nxt = ST_ACK;
      end
      ST_EXIT: begin
        cnt_nxt = cnt_r + 1'h1;
        if (cnt_r == DBP_CNT_W'(DBP_TRI_CYC - 1)) begin
          cnt_nxt = '0;
          st_nxt = ST_RUN;
        end
      end
      default: begin
        st_nxt = ST_RUN;
      end
    endcase
    // Request pulse inside debug mode restarts the command logic
    if (in_cmd_phase && req_assert) begin
      cnt_nxt = '0;
      cmd_nxt = '0;
      sout_nxt = DBP_SOUT_IDLE;
      ackn_nxt = ST_WAITREL;
      st_nxt = ST_ACK;
    end
  end

  always_comb begin
    halt_nxt = (st_nxt != ST_BOOT) && (st_nxt != ST_RUN) &&
      (st_nxt != ST_EXIT);
    dbg_nxt = halt_nxt && (st_nxt != ST_HALTING);
    // Drive status only in run, boot and halting; settle states float
    drive_nxt = (st_nxt == ST_BOOT) || (st_nxt == ST_RUN) ||
      (st_nxt == ST_HALTING);
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_BOOT;
      ackn_r <= ST_WAITREL;
      cnt_r <= '0;
      cmd_r <= '0;
      sr_r <= '0;
      sout_r <= DBP_SOUT_IDLE;
      sclk_p_r <= 1'h0;
      req_n_p_r <= DBP_REQ_IDLE;
      core_wake <= 1'h0;
      core_save_pipe <= 1'h0;
      core_halt_req <= 1'h0;
      debug_mode <= 1'h0;
      drive_r <= 1'h1;
      stat_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      ackn_r <= ackn_nxt;
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
      sr_r <= sr_nxt;
      sout_r <= sout_nxt;
      sclk_p_r <= sclk_s;
      req_n_p_r <= req_n_s;
      core_wake <= wake_nxt;
      core_save_pipe <= save_nxt;
      core_halt_req <= halt_nxt;
      debug_mode <= dbg_nxt;
      drive_r <= drive_nxt;
      stat_r <= drive_nxt ? core_status : 2'h0;
    end
  end

  assign debug_serial_out = sout_r;
  assign chip_status_bit0 = stat_r[0];
  assign chip_status_bit1 = stat_r[1];
  assign chip_status_bit0_oe_n = ~drive_r;
  assign chip_status_bit1_oe_n = ~drive_r;

  localparam int TRI_SETTLE = DBP_TRI_CYC;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_ignore_idle: assert property ((!debug_mode && sclk_fall &&
    st_r != ST_CMD) |=> $stable(cmd_r))
    else $error("command shifted outside debug mode");
  a_msb_first_in: assert property ((st_r == ST_CMD && sclk_fall &&
    !req_assert) |=> (cmd_r[0] == $past(din_s)))
    else $error("serial input not shifted msb first");
  a_status_drive: assert property ((st_r == ST_RUN) |=>
    (!chip_status_bit0_oe_n && !chip_status_bit1_oe_n))
    else $error("status pins not driven in run");
  a_tri_entry: assert property ($rose(chip_status_bit0_oe_n) |->
    (st_r == ST_RELEASE) ##TRI_SETTLE (st_r == ST_ACK))
    else $error("no tri-state settle before input use");
  a_tri_exit: assert property ($fell(chip_status_bit1_oe_n) |->
    $past(st_r) == ST_EXIT)
    else $error("clock pin driven without settle");
  a_out_rise: assert property ((st_r == ST_RD_SHIFT && sclk_rise &&
    !sclk_fall && !req_assert) |=> debug_serial_out == $past(sr_msb))
    else $error("output bit not msb on rising edge");
  a_read_data: assert property ((st_r == ST_RD_FETCH) |=>
    (st_r == ST_RD_LOAD) ##1 (sr_r == $past(reg_rdata)))
    else $error("read data not from addressed register");
  a_ack_pulse: assert property ($rose(st_r == ST_ACK) |=>
    !debug_serial_out [*4])
    else $error("acknowledge pulse too short");
  a_read_ack: assert property ((st_r == ST_RD_LOAD && !req_assert)
    |=> st_r == ST_ACK ##5 st_r == ST_RD_SHIFT)
    else $error("no acknowledge before read data");
  a_write_ack: assert property ((st_r == ST_WR_COMMIT) |=>
    (st_r == ST_ACK) ##1 !debug_serial_out)
    else $error("no acknowledge after write");
  a_req_halt: assert property ((st_r == ST_RUN && req_assert) |=>
    (core_halt_req && core_wake))
    else $error("request did not halt and wake core");
  a_resync: assert property ((in_cmd_phase && req_assert) |=>
    (st_r == ST_ACK && cnt_r == 0 && cmd_r == 0))
    else $error("request in debug did not restart logic");
  a_boot_debug: assert property ((st_r == ST_BOOT &&
    cnt_r == DBP_CNT_W'(DBP_BOOT_CYC - 1) && !req_n_s)
    |=> st_r == ST_RELEASE)
    else $error("held request at reset did not enter debug");

  c_enter_debug: cover property ((st_r == ST_HALTING) ##[1:50]
    (st_r == ST_RELEASE));
  c_read_done: cover property ((st_r == ST_RD_SHIFT) ##[1:1000]
    (st_r == ST_CMD));
  c_write_done: cover property (st_r == ST_WR_COMMIT);
  c_resume: cover property ((st_r == ST_EXIT) ##[1:10] (st_r == ST_RUN));

endmodule : dbp_port

// File: hw/dbp_pkg.sv
// Constants and state type shared by the debug serial port design.
// Assumes a 200 MHz core clock; acknowledge and settle timings derive from DBP_CLK_NS.
package dbp_pkg;

  // Core clock period
  localparam int DBP_CLK_NS = 5;

  // Word sizes of the serial protocol
  localparam int DBP_CMD_W = 8;
  localparam int DBP_DATA_W = 24;
  localparam int DBP_ADDR_W = 3;
  localparam int DBP_REG_N = 8;

  // Command field positions
  localparam int DBP_CMD_RD_BIT = 7;
  localparam int DBP_CMD_GO_BIT = 6;

  // Counter width for bits, acknowledge and settle periods
  localparam int DBP_CNT_W = 6;

  // Acknowledge pulse width, least time, rounded up
  localparam int DBP_ACK_NS = 20;
  localparam int DBP_ACK_CYC = (DBP_ACK_NS + DBP_CLK_NS - 1) / DBP_CLK_NS;

  // Tri-state settle time on a pin direction change, rounded up
  localparam int DBP_TRI_NS = 10;
  localparam int DBP_TRI_CYC = (DBP_TRI_NS + DBP_CLK_NS - 1) / DBP_CLK_NS;

  // Cycles after reset release before the synced request is trusted
  localparam int DBP_BOOT_CYC = 3;

  // Idle levels of the pins
  localparam logic DBP_SOUT_IDLE = 1'h1;
  localparam logic DBP_REQ_IDLE = 1'h1;

  typedef enum logic [3:0] {
    ST_BOOT,
    ST_RUN,
    ST_HALTING,
    ST_RELEASE,
    ST_ACK,
    ST_WAITREL,
    ST_CMD,
    ST_RD_FETCH,
    ST_RD_LOAD,
    ST_RD_SHIFT,
    ST_WR_SHIFT,
    ST_WR_COMMIT,
    ST_EXIT
  } dbp_state_t;

endpackage : dbp_pkg

// File: hw/dbp_sync.sv
// Two-flop synchroniser for a bundle of single-bit pin inputs.
// Assumes inputs are asynchronous to mclk; reset value is a constant.
`timescale 1ns/1ps
module dbp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= meta_nxt;
      q <= q_nxt;
    end
  end

endmodule : dbp_sync

// File: hw/dbp_regs.sv
// Internal debug register file reached by serial commands.
// Assumes one access per cycle; read data are registered, one cycle late.
`timescale 1ns/1ps
module dbp_regs
  import dbp_pkg::*;
#(
  parameter int DATA_W = DBP_DATA_W,
  parameter int ADDR_W = DBP_ADDR_W,
  parameter int DEPTH = DBP_REG_N
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic we,
  input wire logic re,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rdata_nxt;

  always_comb begin
    rdata_nxt = rdata;
    if (re) begin
      rdata_nxt = mem[addr];
    end
  end

  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_nxt;
    end
  end

endmodule : dbp_regs

// File: dv/dbp_ctl_model.sv
// Behavioural model of the external debug command controller.
// Assumes the bench resolves the shared pins from both drivers' enables.
`timescale 1ns/1ps
module dbp_ctl_model (
  input wire logic mclk,
  input wire logic debug_serial_out,
  output logic drive_en,
  output logic shift_clk,
  output logic shift_data,
  output logic debug_request_n
);
  initial begin
    drive_en = 1'h0;
    shift_clk = 1'h0;
    shift_data = 1'h0;
    debug_request_n = 1'h1;
  end

  task automatic set_req(input logic v);
    @(negedge mclk);
    debug_request_n = v;
  endtask : set_req

  // Width in mclk cycles of the next low pulse, 0 if none comes
  task automatic wait_ack(output int w);
    int n;
    w = 0;
    n = 0;
    while (debug_serial_out !== 1'h0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    while (debug_serial_out === 1'h0 && w < 20) begin
      @(negedge mclk);
      w++;
    end
  endtask : wait_ack

  // Request, then release only after the acknowledge
  task automatic enter(output int w);
    set_req(1'h0);
    wait_ack(w);
    set_req(1'h1);
    drive_en = 1'h1;
  endtask : enter

  task automatic park();
    drive_en = 1'h0;
    shift_data = 1'h0;
  endtask : park

  // Data set in the low phase; output looked at just before each fall
  task automatic shift(input logic [23:0] v, input int n,
                       output logic [23:0] got);
    got = 24'h0;
    #1.3;
    for (int i = n - 1; i >= 0; i--) begin
      #20 shift_data = v[i];
      #20 shift_clk = 1'h1;
      #40 got = {got[22:0], debug_serial_out};
      shift_clk = 1'h0;
    end
  endtask : shift
endmodule : dbp_ctl_model

// File: dv/dbp_port_test.sv
// Self-checking bench for the debug serial port.
// Assumes the controller model drives the shared pins only in debug mode.
`timescale 1ns/1ps
module dbp_port_test;
  import dbp_pkg::*;

  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic [1:0] core_status = 2'h0;
  logic core_instr_done = 1'h0;
  logic cs0, cs0_oe_n, cs1, cs1_oe_n, sout;
  logic halt, save, wake, dmode;
  logic m_en, m_clk, m_data, req_n;
  logic pin_data, pin_clk;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_wake = 0;
  int n_save = 0;
  int w;
  logic [23:0] got;

  // Pull-downs hold both shared pins low when nobody drives them
  assign pin_data = !cs0_oe_n ? cs0 : (m_en ? m_data : 1'h0);
  assign pin_clk = !cs1_oe_n ? cs1 : (m_en ? m_clk : 1'h0);

  always #2.5 mclk = ~mclk;

  dbp_port u_dut (
    .mclk(mclk), .rstn(rstn), .debug_data_in(pin_data),
    .chip_status_bit0(cs0), .chip_status_bit0_oe_n(cs0_oe_n),
    .debug_shift_clock(pin_clk), .chip_status_bit1(cs1),
    .chip_status_bit1_oe_n(cs1_oe_n), .debug_serial_out(sout),
    .debug_request_n(req_n), .core_status(core_status),
    .core_instr_done(core_instr_done), .core_halt_req(halt),
    .core_save_pipe(save), .core_wake(wake), .debug_mode(dmode)
  );

  dbp_ctl_model u_ctl (
    .mclk(mclk), .debug_serial_out(sout), .drive_en(m_en),
    .shift_clk(m_clk), .shift_data(m_data), .debug_request_n(req_n)
  );

  task automatic finish_test();
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  always @(posedge mclk) begin
    cyc++;
    if (wake === 1'h1) n_wake++;
    if (save === 1'h1) n_save++;
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic do_reset();
    @(negedge mclk);
    rstn = 1'h0;
    repeat (5) @(negedge mclk);
    chk("reset oe_n", 24'h0, {cs1_oe_n, cs0_oe_n});
    chk("reset status", 24'h0, {cs1, cs0});
    chk("reset sout", 24'h1, sout);
    rstn = 1'h1;
    @(negedge mclk);
  endtask : do_reset

  task automatic t_run();
    repeat (10) @(negedge mclk);
    // Last step drops both pins: a clock fall the port must ignore
    for (int s = 1; s < 5; s++) begin
      core_status = s[1:0];
      repeat (3) @(negedge mclk);
      chk("run status", {22'h0, s[1:0]}, {cs1, cs0});
      chk("run oe_n", 24'h0, {cs1_oe_n, cs0_oe_n});
    end
  endtask : t_run

  task automatic t_entry();
    n_wake = 0;
    n_save = 0;
    fork
      u_ctl.enter(w);
      begin
        repeat (30) @(negedge mclk);
        chk("halt_req", 24'h1, halt);
        chk("wake pulses", 24'h1, n_wake);
        chk("mode before done", 24'h0, dmode);
        core_instr_done = 1'h1;
      end
    join
    core_instr_done = 1'h0;
    chk("entry ack", DBP_ACK_CYC, w);
    chk("save pulses", 24'h1, n_save);
    chk("debug_mode", 24'h1, dmode);
    chk("debug oe_n", 24'h3, {cs1_oe_n, cs0_oe_n});
  endtask : t_entry

  task automatic t_write(input logic [2:0] a, input logic [23:0] v);
    u_ctl.shift({21'h0, a}, 8, got);
    u_ctl.wait_ack(w);
    chk("write ready ack", DBP_ACK_CYC, w);
    u_ctl.shift(v, 24, got);
    u_ctl.wait_ack(w);
    chk("write done ack", DBP_ACK_CYC, w);
  endtask : t_write

  task automatic t_read(input logic [2:0] a, input logic [23:0] exp);
    u_ctl.shift({16'h0, 5'h10, a}, 8, got);
    u_ctl.wait_ack(w);
    chk("read ack", DBP_ACK_CYC, w);
    u_ctl.shift(24'h0, 24, got);
    chk("read data", exp, got);
  endtask : t_read

  // Three bits of a command, then a request pulse restarts the command logic
  task automatic t_resync();
    u_ctl.shift(24'h5, 3, got);
    u_ctl.enter(w);
    chk("resync ack", DBP_ACK_CYC, w);
    chk("resync mode", 24'h1, dmode);
    t_read(3'h7, 24'h3C5A69);
  endtask : t_resync

  task automatic t_resume();
    core_status = 2'h2;
    u_ctl.shift(24'h40, 8, got);
    u_ctl.park();
    for (int n = 0; n < 50 && cs0_oe_n !== 1'h0; n++) @(negedge mclk);
    repeat (2) @(negedge mclk);
    chk("resume mode", 24'h0, dmode);
    chk("resume halt", 24'h0, halt);
    chk("resume oe_n", 24'h0, {cs1_oe_n, cs0_oe_n});
    chk("resume status", 24'h2, {cs1, cs0});
  endtask : t_resume

  task automatic t_boot_debug();
    u_ctl.set_req(1'h0);
    do_reset();
    u_ctl.enter(w);
    chk("boot ack", DBP_ACK_CYC, w);
    chk("boot mode", 24'h1, dmode);
    t_write(3'h5, 24'h5A3C69);
    t_read(3'h5, 24'h5A3C69);
  endtask : t_boot_debug

  initial begin
    do_reset();
    t_run();
    t_entry();
    t_write(3'h0, 24'hA5C396);
    t_write(3'h7, 24'h3C5A69);
    t_read(3'h0, 24'hA5C396);
    t_read(3'h7, 24'h3C5A69);
    t_resync();
    t_resume();
    t_boot_debug();
    finish_test();
  end
endmodule : dbp_port_test
